// ### hdl/rcb_pkg.sv
// Shared constants and types for the coprocessor execute slice.
// Assumes a 16-bit instruction word and one bus clock for the whole slice.
package rcb_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned REG_IDX_W = 3;
	localparam int unsigned NUM_REGS = 8;

	// Immediate AND on the upper byte: opcode in [15:11]
	localparam logic [4:0] AND_HIGH_BYTE_IMMEDIATE_OPC = 5'h11;
	localparam int unsigned AND_HIGH_BYTE_IMMEDIATE_LSB = 11;
	localparam int unsigned RD_LSB = 8;

	// Branch on carry clear: opcode in [15:9], offset in [8:0]
	localparam logic [6:0] BRANCH_CARRY_CLEAR_OPC = 7'h10;
	localparam int unsigned BRANCH_CARRY_CLEAR_LSB = 9;
	localparam int unsigned REL_W = 9;

	localparam logic [15:0] PC_STEP = 16'h0002;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// Sign, zero, overflow, carry position in the flag vector
	localparam int unsigned FLAG_N = 3;
	localparam int unsigned FLAG_Z = 2;
	localparam int unsigned FLAG_V = 1;
	localparam int unsigned FLAG_C = 0;
	localparam logic [3:0] FLAGS_RESET = 4'h0;

	// Error causes
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_OPCODE = 2'h1;
	localparam logic [1:0] ERR_FETCH = 2'h2;
	localparam logic [1:0] ERR_ACCESS = 2'h3;

	typedef enum logic [1:0] {
		RCB_IDLE = 2'b00,
		RCB_FETCH = 2'b01,
		RCB_REFILL = 2'b10,
		RCB_HALT = 2'b11
	} rcb_state_e;
endpackage

// ### hdl/rcb_dec_if.sv
// Decoded-instruction bundle between the execute core and its decoder.
// Purely combinational signals; no clock lives here.
`timescale 1ns/1ps
interface rcb_dec_if;
	logic [15:0] instr;
	logic is_and_high_byte_immediate;
	logic is_branch_carry_clear;
	logic illegal;
	logic [2:0] rd;
	logic [7:0] imm;
	logic [8:0] rel;

	modport core (output instr, input is_and_high_byte_immediate, is_branch_carry_clear, illegal, rd, imm, rel);
	modport dec (input instr, output is_and_high_byte_immediate, is_branch_carry_clear, illegal, rd, imm, rel);
endinterface

// ### hdl/rcb_decode.sv
// Instruction decoder for the execute slice.
// Assumes the instruction word is stable while the core samples the result.
`timescale 1ns/1ps
module rcb_decode (
	// Decoded bundle
	rcb_dec_if.dec d
);
	always_comb begin
		d.is_and_high_byte_immediate =
			d.instr[15:rcb_pkg::AND_HIGH_BYTE_IMMEDIATE_LSB] == rcb_pkg::AND_HIGH_BYTE_IMMEDIATE_OPC;
		d.is_branch_carry_clear =
			d.instr[15:rcb_pkg::BRANCH_CARRY_CLEAR_LSB] == rcb_pkg::BRANCH_CARRY_CLEAR_OPC;
		d.illegal = !(d.is_and_high_byte_immediate || d.is_branch_carry_clear);
		d.rd = d.instr[rcb_pkg::RD_LSB +: rcb_pkg::REG_IDX_W];
		d.imm = d.instr[7:0];
		d.rel = d.instr[rcb_pkg::REL_W-1:0];
	end
endmodule // rcb_decode

// ### hdl/rcb_exec.sv
// Execute slice of the coprocessor: upper-byte immediate AND, carry-clear
// branch, and software error detection that halts the thread.
// Assumes the memory controller answers one fetch at a time and flags
// illegal fetches and data accesses in the same cycle as the access.
// Register contents change only through the upper-byte AND in this slice.
`timescale 1ns/1ps

// Functional notes
// - Any software error halts execution at once; no further instruction completes.
// - Opcodes outside the defined set are illegal and raise a software error.
// - Fetches or data accesses flagged illegal by the memory controller raise an error.
// - Upper byte ANDed with 8-bit constant; lower byte unchanged.
// - Negative flag takes bit 15 of the result register.
// - Zero set when result byte is zero; overflow cleared; carry kept.
// - AND encoded 10001, register, immediate; one fetch cycle.
// - Carry clear branch: PC plus 2 plus doubled signed offset; flags unchanged.
// - Branch encoded 0010000 then 9-bit offset; timing differs taken versus not.
module rcb_exec (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Thread control
	input wire logic start,
	input wire logic [15:0] start_pc,
	output logic running,
	output logic halted,
	// Instruction fetch
	output logic fetch_req,
	output logic [15:0] fetch_addr,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_data,
	input wire logic fetch_illegal,
	// Data access legality from the memory controller
	input wire logic access_illegal,
	// Status
	output logic sw_error,
	output logic [1:0] error_cause,
	output logic [15:0] pc,
	output logic [3:0] condition_flags,
	output logic retire,
	// Register inspection
	input wire logic [2:0] dbg_sel,
	output logic [15:0] dbg_data
);
	rcb_pkg::rcb_state_e state_reg, state_next;
	logic [15:0] pc_reg, pc_next;
	logic [3:0] flags_reg, flags_next;
	logic err_reg, err_next;
	logic [1:0] cause_reg, cause_next;
	logic retire_reg, retire_next;
	logic [15:0] dbg_reg, dbg_next;
	logic [15:0] regs [rcb_pkg::NUM_REGS];
	logic [15:0] regs_next [rcb_pkg::NUM_REGS];
	// Combinational write port of the register file
	logic rf_we;
	logic [2:0] rf_sel;
	logic [15:0] rf_wdata;
	logic [15:0] rd_val;
	logic [7:0] and_byte;

	// Decoded fields travel as one bundle
	rcb_dec_if dec_bus ();

	rcb_decode u_decode (
		.d(dec_bus.dec)
	);

	// Doubled, sign-extended branch displacement
	function automatic logic [15:0] rel_disp(input logic [8:0] rel);
		logic [15:0] ext;
		ext = {{7{rel[8]}}, rel};
		return {ext[14:0], 1'b0};
	endfunction

	// Sequential successor of an instruction address
	function automatic logic [15:0] next_seq(input logic [15:0] cur);
		return cur + rcb_pkg::PC_STEP;
	endfunction

	// Decoder sees the raw fetch bus; its result counts only with fetch_valid
	assign dec_bus.instr = fetch_data;
	assign rd_val = regs[dec_bus.rd];
	assign and_byte = rd_val[15:8] & dec_bus.imm;

	// Next state for control and status
	always_comb begin
		state_next = state_reg;
		pc_next = pc_reg;
		flags_next = flags_reg;
		err_next = err_reg;
		cause_next = cause_reg;
		retire_next = 1'b0;
		rf_we = 1'b0;
		rf_sel = dec_bus.rd;
		rf_wdata = rd_val;
		dbg_next = regs[dbg_sel];
		case (state_reg)
			// Restart clears only the error; flags and registers carry over
			rcb_pkg::RCB_IDLE, rcb_pkg::RCB_HALT: begin
				if (start) begin
					state_next = rcb_pkg::RCB_FETCH;
					pc_next = start_pc;
					err_next = 1'b0;
					cause_next = rcb_pkg::ERR_NONE;
				end
			end
			rcb_pkg::RCB_FETCH: begin
				// Priority access, fetch, opcode: one cause is kept
				if (access_illegal) begin
					// illegal data access stops the thread
					state_next = rcb_pkg::RCB_HALT;
					err_next = 1'b1;
					cause_next = rcb_pkg::ERR_ACCESS;
				end else if (fetch_valid && fetch_illegal) begin
					state_next = rcb_pkg::RCB_HALT;
					err_next = 1'b1;
					cause_next = rcb_pkg::ERR_FETCH;
				end else if (fetch_valid && dec_bus.illegal) begin
					// unknown opcode, halt before any update
					state_next = rcb_pkg::RCB_HALT;
					err_next = 1'b1;
					cause_next = rcb_pkg::ERR_OPCODE;
				end else if (fetch_valid && dec_bus.is_and_high_byte_immediate) begin
					// write upper byte, keep lower byte
					rf_we = 1'b1;
					rf_wdata = {and_byte, rd_val[7:0]};
					flags_next[rcb_pkg::FLAG_N] = and_byte[7];
					// zero on result byte, overflow cleared, carry kept
					flags_next[rcb_pkg::FLAG_Z] = and_byte == 8'h00;
					flags_next[rcb_pkg::FLAG_V] = 1'b0;
					pc_next = next_seq(pc_reg);
					retire_next = 1'b1;
				end else if (fetch_valid && dec_bus.is_branch_carry_clear) begin
					retire_next = 1'b1;
					// Carry is never written here, so every branch after reset is taken
					if (!flags_reg[rcb_pkg::FLAG_C]) begin
						pc_next = next_seq(pc_reg) + rel_disp(dec_bus.rel);
						// extra cycle to refill the stream
						state_next = rcb_pkg::RCB_REFILL;
					end else begin
						// not taken falls through in one cycle
						pc_next = next_seq(pc_reg);
					end
				end
			end
			// Fetch held off one cycle so no word in flight is taken
			rcb_pkg::RCB_REFILL: begin
				if (access_illegal) begin
					state_next = rcb_pkg::RCB_HALT;
					err_next = 1'b1;
					cause_next = rcb_pkg::ERR_ACCESS;
				end else begin
					state_next = rcb_pkg::RCB_FETCH;
				end
			end
			default: begin
				state_next = rcb_pkg::RCB_IDLE;
			end
		endcase
	end

	// Control and status registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= rcb_pkg::RCB_IDLE;
			pc_reg <= rcb_pkg::PC_RESET;
			flags_reg <= rcb_pkg::FLAGS_RESET;
			err_reg <= 1'b0;
			cause_reg <= rcb_pkg::ERR_NONE;
			retire_reg <= 1'b0;
			dbg_reg <= rcb_pkg::REG_RESET;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			flags_reg <= flags_next;
			err_reg <= err_next;
			cause_reg <= cause_next;
			retire_reg <= retire_next;
			dbg_reg <= dbg_next;
		end
	end

	// Register file next state; only the decoded destination changes
	always_comb begin
		regs_next = regs;
		if (rf_we) begin
			regs_next[rf_sel] = rf_wdata;
		end
	end

	// Register file is reset so inspection never shows unknowns
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < rcb_pkg::NUM_REGS; i++) begin
				regs[i] <= rcb_pkg::REG_RESET;
			end
		end else begin
			regs <= regs_next;
		end
	end

	// Fetch request is combinational so the memory sees the PC without a bubble
	assign fetch_req = state_reg == rcb_pkg::RCB_FETCH;
	assign fetch_addr = pc_reg;
	assign running = state_reg == rcb_pkg::RCB_FETCH || state_reg == rcb_pkg::RCB_REFILL;
	assign halted = state_reg == rcb_pkg::RCB_HALT;

	// Status comes straight from flip-flops
	assign sw_error = err_reg;
	assign error_cause = cause_reg;
	assign pc = pc_reg;
	assign condition_flags = flags_reg;
	assign retire = retire_reg;
	assign dbg_data = dbg_reg;
endmodule // rcb_exec

// ### verification/rcb_checker.sv
// Port assertions for the execute slice.
// Assumes one clock and an active-high async reset.
`timescale 1ns/1ps
module rcb_checker (
	// Clock and control
	input wire logic clk, rst, start,
	// Fetch link
	input wire logic fetch_req, fetch_valid, fetch_illegal, access_illegal,
	input wire logic [15:0] fetch_addr, fetch_data,
	// Status
	input wire logic halted, sw_error, retire,
	input wire logic [1:0] error_cause,
	input wire logic [15:0] pc,
	input wire logic [3:0] condition_flags
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire go = fetch_req && fetch_valid && !fetch_illegal && !access_illegal;
	wire is_and = fetch_data[15:11] == rcb_pkg::AND_HIGH_BYTE_IMMEDIATE_OPC;
	wire is_branch = fetch_data[15:9] == rcb_pkg::BRANCH_CARRY_CLEAR_OPC;
	wire [15:0] dst = pc + 16'h0002 + {{6{fetch_data[8]}}, fetch_data[8:0], 1'b0};
	sequence s_refill;
		!fetch_req ##1 fetch_req && fetch_addr == pc;
	endsequence
	a_halt_hold: assert property (halted && !start |=> halted && !retire && $stable(pc))
		else $error("halt left");
	a_halt_quiet: assert property (halted |-> !fetch_req && sw_error)
		else $error("halted yet fetching");
	a_access_err: assert property (fetch_req && access_illegal |=> halted && error_cause == 2'h3)
		else $error("access error missed");
	a_fetch_err: assert property (fetch_req && fetch_valid && fetch_illegal && !access_illegal |=>
		halted && error_cause == 2'h2) else $error("fetch error missed");
	a_opcode_err: assert property (go && !is_and && !is_branch |=> halted && error_cause == 2'h1 && $stable(pc))
		else $error("opcode error missed");
	a_and_step: assert property (go && is_and |=> retire && fetch_req && pc == $past(pc) + 16'h0002 &&
		!condition_flags[1] && condition_flags[0] == $past(condition_flags[0])) else $error("and step");
	a_and_zero: assert property (go && is_and && fetch_data[7:0] == 8'h00 |=> condition_flags[3:2] == 2'h1)
		else $error("and flags");
	a_branch_taken: assert property (go && is_branch && !condition_flags[0] |=> pc == $past(dst) &&
		$stable(condition_flags) ##0 s_refill) else $error("branch");
endmodule // rcb_checker

bind rcb_exec rcb_checker u_chk (.clk(clk), .rst(rst), .start(start), .fetch_req(fetch_req),
	.fetch_valid(fetch_valid), .fetch_illegal(fetch_illegal), .access_illegal(access_illegal),
	.fetch_addr(fetch_addr), .fetch_data(fetch_data), .halted(halted), .sw_error(sw_error),
	.retire(retire), .error_cause(error_cause), .pc(pc), .condition_flags(condition_flags));

// ### verification/rcb_mem.sv
// Memory and memory-controller model on the fetch side.
// Assumes the bench fills mem and the flagged addresses between runs.
`timescale 1ns/1ps
module rcb_mem (
	// Clock and pacing
	input wire logic clk,
	input wire logic slow,
	// Fetch link
	input wire logic fetch_req,
	input wire logic [15:0] fetch_addr,
	output logic fetch_valid,
	output logic [15:0] fetch_data,
	output logic fetch_illegal,
	output logic access_illegal
);
	logic [15:0] mem [logic [15:0]];
	// Odd addresses are never fetched, so they disarm the flags
	logic [15:0] ill_a = 16'h0001;
	logic [15:0] acc_a = 16'h0001;
	logic hold = 1'b0;
	initial begin
		{fetch_valid, fetch_illegal, access_illegal} = 3'h0;
		fetch_data = 16'h0000;
	end
	always @(posedge clk) begin
		#1;
		hold = slow && !hold && fetch_req;
		fetch_valid = fetch_req && !hold;
		fetch_illegal = fetch_valid && fetch_addr == ill_a;
		access_illegal = fetch_req && fetch_addr == acc_a;
		// Idle data toggles so stale words never look valid
		fetch_data = !fetch_valid ? ~fetch_data : mem.exists(fetch_addr) ? mem[fetch_addr] : 16'hffff;
	end
endmodule // rcb_mem

// ### verification/risc_coproc_and_branch_exec_test.sv
// Random instruction streams, each ending in a software error.
// Assumes the fetch-side model answers every fetch.
`timescale 1ns/1ps
module risc_coproc_and_branch_exec_test;
	logic clk = 1'b0, rst = 1'b1, start = 1'b0, slow = 1'b0, h_seen = 1'b0;
	logic running, halted, fetch_req, fetch_valid, fetch_illegal, access_illegal, sw_error, retire;
	logic [15:0] start_pc = 16'h0000, fetch_addr, fetch_data, pc, dbg_data;
	logic [2:0] dbg_sel = 3'h0;
	logic [1:0] error_cause;
	logic [3:0] condition_flags, fl = 4'h0;
	logic [22:0] q[$], e;
	int err_count = 0, total_checks = 0;
	rcb_exec rcb_exec_i (.clk(clk), .rst(rst), .start(start), .start_pc(start_pc), .running(running),
		.halted(halted), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
		.fetch_data(fetch_data), .fetch_illegal(fetch_illegal), .access_illegal(access_illegal),
		.sw_error(sw_error), .error_cause(error_cause), .pc(pc), .condition_flags(condition_flags),
		.retire(retire), .dbg_sel(dbg_sel), .dbg_data(dbg_data));
	rcb_mem rcb_mem_i (.clk(clk), .slow(slow), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
		.fetch_valid(fetch_valid), .fetch_data(fetch_data), .fetch_illegal(fetch_illegal),
		.access_illegal(access_illegal));
	initial forever #50 clk = ~clk;
	task automatic chk(logic [22:0] got, logic [22:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		#2;
		if (retire || (halted && !h_seen)) begin
			e = q.size() ? q.pop_front() : 'x;
			chk({halted, error_cause, pc, condition_flags}, e);
			chk({21'h000000, running, sw_error}, {21'h000000, !e[22], e[22]});
		end
		h_seen = halted;
	end
	task automatic run(int n, int kind);
		logic [15:0] a, nx, w;
		a = 16'($urandom) & 16'hfffe;
		rcb_mem_i.mem.delete();
		{rcb_mem_i.ill_a, rcb_mem_i.acc_a} = {16'h0001, 16'h0001};
		start_pc = a;
		for (int i = 0; i < n; i++) begin
			w = 16'($urandom);
			// legal encodings
			// Half of the upper-byte ANDs carry a zero constant
			if (w[0]) w = {rcb_pkg::AND_HIGH_BYTE_IMMEDIATE_OPC, w[10:8], w[7:0] & {8{w[1]}}};
			else w = {rcb_pkg::BRANCH_CARRY_CLEAR_OPC, w[8:0]};
			nx = a + 16'h0002 + (fl[0] ? 16'h0000 : {{6{w[8]}}, w[8:0], 1'b0});
			if (w[15:11] == rcb_pkg::AND_HIGH_BYTE_IMMEDIATE_OPC) nx = a + 16'h0002;
			if (nx == a || rcb_mem_i.mem.exists(nx)) break;
			rcb_mem_i.mem[a] = w;
			if (w[15:11] == rcb_pkg::AND_HIGH_BYTE_IMMEDIATE_OPC) fl[3:1] = 3'h2;
			q.push_back({1'b0, rcb_pkg::ERR_NONE, nx, fl});
			a = nx;
		end
		w = 16'($urandom);
		if (w[15:11] == rcb_pkg::AND_HIGH_BYTE_IMMEDIATE_OPC ||
			w[15:9] == rcb_pkg::BRANCH_CARRY_CLEAR_OPC) w[15] = ~w[15];
		rcb_mem_i.mem[a] = w;
		// Flags stack up so error priority is exercised
		if (kind > 1) rcb_mem_i.ill_a = a;
		if (kind > 2) rcb_mem_i.acc_a = a;
		q.push_back({1'b1, 2'(kind), a, fl});
		@(posedge clk);
		#1 start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		for (int i = 0; i < 400 && !halted; i++) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		if (!halted || q.size() > 0) begin
			err_count++;
			summarize();
		end
	endtask
	initial begin
		void'($urandom(80));
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		for (int k = 0; k < 12; k++) begin
			slow = k[0];
			run(1 + k * 2, 1 + k % 3);
		end
		for (int r = 0; r < 8; r++) begin
			dbg_sel = 3'(r);
			repeat (2) @(posedge clk);
			#1 chk({7'h00, dbg_data}, 23'h0);
		end
		summarize();
	end
endmodule // risc_coproc_and_branch_exec_test
